// ---- hdl/port_power_consts.svh ----
// Constants for the downstream port power and over-current block.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef PORT_POWER_CONSTS_SVH
`define PORT_POWER_CONSTS_SVH

`define PPS_CLK_MHZ        125
`define PPS_SINGLE_MS      5
`define PPS_DOUBLE_MS      20
// Least time rounds up, longest rounds down; both are exact at 125 MHz
`define PPS_SINGLE_CYC     ((`PPS_SINGLE_MS * `PPS_CLK_MHZ * 1000))
`define PPS_DOUBLE_CYC     ((`PPS_DOUBLE_MS * `PPS_CLK_MHZ * 1000))
`define PPS_CNT_W          22

`define PPS_ADDR_CTRL      4'h0
`define PPS_ADDR_STATUS    4'h1
`define PPS_ADDR_MASK      4'h2
`define PPS_ADDR_PINS      4'h3

`define PPS_CTRL_PWR_LSB   0
`define PPS_CTRL_GANG_BIT  4
`define PPS_CTRL_PROC_BIT  5
`define PPS_CTRL_BC_LSB    8
`define PPS_CTRL_RESET     10'h000
`define PPS_MASK_RESET     4'h0

`endif

// ---- hdl/port_power_pkg.sv ----
// Types for the downstream port power and over-current block.
// Assumes the constants header is included by users needing numbers.
package port_power_pkg;

  typedef struct packed {
    logic [3:0] pwrEn;
    logic       gang;
    logic       procSel;
    logic [3:0] bcEn;
  } port_ctrl_t;

  typedef enum logic [3:0] {
    FLT_IDLE  = 4'b0001,
    FLT_LOW1  = 4'b0010,
    FLT_GAP   = 4'b0100,
    FLT_TRIP  = 4'b1000
  } flt_state_t;

endpackage

// ---- hdl/port_power_sense_ctl.sv ----
// Contract
// RULE_01 - One pin per port both switches power and senses over-current.
// RULE_02 - Port power comes from hub logic or from the processor.
// RULE_03 - Ganged or combined port arrangement is selectable.
// RULE_04 - Ganged: one shared pin switches and senses all ports.
// RULE_05 - Combined: each port has its own control and sense pin.
// RULE_06 - Disabled port: pin driven low, pull-up off.
// RULE_07 - Enabled port: driver off, pull-up on, open-drain line.
// RULE_08 - External switch pulls the line low on over-current.
// RULE_09 - Low on an enabled pin reads as over-current.
// RULE_10 - Sense input is filtered so transient lows are ignored.
// RULE_11 - Sample only while the port is enabled.
// RULE_12 - Continuous low for the single-pulse time is an event.
// RULE_13 - Two low groups within the double-pulse window is an event.
// RULE_14 - Per-port battery charging indication from configuration.
// RULE_15 - Single low pulse must last at least 5 ms.
// RULE_16 - Double-pulse window is at most 20 ms.
// RULE_17 - Over-current is latched per port until cleared.
//
// Four-port power control with Avalon-MM slave. Pin 0 is the shared pin
// in ganged mode. Pull-ups are external or pad-level, driven by pullUpEn.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ns
`include "port_power_consts.svh"

module port_power_sense_ctl #(
  parameter int unsigned SINGLE_CYC = `PPS_SINGLE_CYC,
  parameter int unsigned DOUBLE_CYC = `PPS_DOUBLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  input  wire logic [3:0]  hubPwrReq,
  input  wire logic [3:0]  portPowerSensePinsIn,
  output logic      [3:0]  portPowerSensePinsOut,
  output logic      [3:0]  portPowerSensePinsOe,
  output logic      [3:0]  pullUpEn,
  output logic      [3:0]  overCurrent,
  output logic      [3:0]  battChargeEn,
  output logic             irq
);

  port_power_pkg::port_ctrl_t ctrl_q, ctrl_d;
  logic [3:0]  status_q, status_d;
  logic [3:0]  mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic [3:0]  portOn;
  logic [3:0]  pinOn;
  logic [3:0]  lowSeen;
  logic [3:0]  event_s;
  logic        wrHit;

  function automatic logic [31:0] ctrlWord(
    input port_power_pkg::port_ctrl_t c);
    logic [31:0] w;
    w = 32'h0;
    w[`PPS_CTRL_PWR_LSB +: 4]  = c.pwrEn;
    w[`PPS_CTRL_GANG_BIT]      = c.gang;
    w[`PPS_CTRL_PROC_BIT]      = c.procSel;
    w[`PPS_CTRL_BC_LSB +: 4]   = c.bcEn;
    return w;
  endfunction

  // Power source choice and arrangement
  always_comb begin
    portOn = ctrl_q.procSel ? ctrl_q.pwrEn : hubPwrReq;  // [RULE_02]
    if (ctrl_q.gang) begin
      pinOn = {3'b000, |portOn};                        // [RULE_03] [RULE_04]
    end else begin
      pinOn = portOn;                                   // [RULE_05] [RULE_01]
    end
  end

  // Disabled pins drive 0; enabled pins release and pull up
  always_comb begin
    portPowerSensePinsOut = 4'h0;                       // [RULE_06]
    portPowerSensePinsOe  = ~pinOn;                     // [RULE_06] [RULE_07]
    pullUpEn              = pinOn;                      // [RULE_07]
    // Input read with driver off, so external pull-down is seen cleanly
    lowSeen = pinOn & ~portPowerSensePinsIn;            // [RULE_09] [RULE_08]
  end

  // Per-pin filter: a slow counter per pin would be too costly with a
  // shared window; each pin keeps its own run and window counters.
  port_power_pkg::flt_state_t fst_q [4], fst_d [4];
  logic [`PPS_CNT_W-1:0] run_q [4], run_d [4];
  logic [`PPS_CNT_W-1:0] win_q [4], win_d [4];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      fst_d[i]   = fst_q[i];
      run_d[i]   = run_q[i];
      win_d[i]   = win_q[i];
      event_s[i] = 1'b0;
      if (!pinOn[i]) begin
        fst_d[i] = port_power_pkg::FLT_IDLE;            // [RULE_11]
        run_d[i] = '0;
        win_d[i] = '0;
      end else begin
        case (fst_q[i])
          port_power_pkg::FLT_IDLE: begin
            if (lowSeen[i]) begin
              fst_d[i] = port_power_pkg::FLT_LOW1;
              run_d[i] = `PPS_CNT_W'(1);
              win_d[i] = `PPS_CNT_W'(1);
            end
          end
          port_power_pkg::FLT_LOW1: begin
            win_d[i] = win_q[i] + 1'b1;
            if (lowSeen[i]) begin
              run_d[i] = run_q[i] + 1'b1;
              if (run_q[i] + 1'b1 >= `PPS_CNT_W'(SINGLE_CYC)) begin
                fst_d[i] = port_power_pkg::FLT_TRIP;    // [RULE_12] [RULE_15]
                event_s[i] = 1'b1;
              end
            end else begin
              fst_d[i] = port_power_pkg::FLT_GAP;       // [RULE_10]
              run_d[i] = '0;
            end
          end
          port_power_pkg::FLT_GAP: begin
            win_d[i] = win_q[i] + 1'b1;
            if (win_q[i] >= `PPS_CNT_W'(DOUBLE_CYC)) begin
              fst_d[i] = port_power_pkg::FLT_IDLE;      // [RULE_16] [RULE_10]
            end else if (lowSeen[i]) begin
              fst_d[i] = port_power_pkg::FLT_TRIP;      // [RULE_13]
              event_s[i] = 1'b1;
            end
          end
          port_power_pkg::FLT_TRIP: begin
            if (!lowSeen[i]) begin
              fst_d[i] = port_power_pkg::FLT_IDLE;
              run_d[i] = '0;
              win_d[i] = '0;
            end
          end
          default: fst_d[i] = port_power_pkg::FLT_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        fst_q[i] <= port_power_pkg::FLT_IDLE;
        run_q[i] <= '0;
        win_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        fst_q[i] <= fst_d[i];
        run_q[i] <= run_d[i];
        win_q[i] <= win_d[i];
      end
    end
  end

  // Avalon slave: one wait cycle, answer on the second edge
  assign wrHit = avsWrite && ack_q;
  assign avsWaitrequest = (avsRead || avsWrite) && !ack_q;

  always_comb begin
    ctrl_d   = ctrl_q;
    mask_d   = mask_q;
    rdata_d  = rdata_q;
    ack_d    = (avsRead || avsWrite) && !ack_q;
    status_d = status_q;
    if (wrHit && avsAddress == `PPS_ADDR_STATUS && avsByteenable[0]) begin
      status_d = status_q & ~avsWritedata[3:0];
    end
    status_d = status_d | event_s;                      // [RULE_17]
    if (wrHit && avsAddress == `PPS_ADDR_CTRL) begin
      if (avsByteenable[0]) begin
        ctrl_d.pwrEn   = avsWritedata[`PPS_CTRL_PWR_LSB +: 4];
        ctrl_d.gang    = avsWritedata[`PPS_CTRL_GANG_BIT];
        ctrl_d.procSel = avsWritedata[`PPS_CTRL_PROC_BIT];
      end
      if (avsByteenable[1]) begin
        ctrl_d.bcEn = avsWritedata[`PPS_CTRL_BC_LSB +: 4];
      end
    end else if (wrHit && avsAddress == `PPS_ADDR_MASK) begin
      if (avsByteenable[0]) begin
        mask_d = avsWritedata[3:0];
      end
    end
    if (avsRead && !ack_q) begin
      if (avsAddress == `PPS_ADDR_CTRL) begin
        rdata_d = ctrlWord(ctrl_q);
      end else if (avsAddress == `PPS_ADDR_STATUS) begin
        rdata_d = {28'h0, status_q};
      end else if (avsAddress == `PPS_ADDR_MASK) begin
        rdata_d = {28'h0, mask_q};
      end else if (avsAddress == `PPS_ADDR_PINS) begin
        rdata_d = {20'h0, pinOn, portPowerSensePinsIn, portOn};
      end else begin
        rdata_d = 32'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= port_power_pkg::port_ctrl_t'(`PPS_CTRL_RESET);
      status_q <= 4'h0;
      mask_q   <= `PPS_MASK_RESET;
      rdata_q  <= 32'h0;
      ack_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      status_q <= status_d;
      mask_q   <= mask_d;
      rdata_q  <= rdata_d;
      ack_q    <= ack_d;
    end
  end

  assign avsReaddata  = rdata_q;
  assign overCurrent  = status_q;                       // [RULE_17]
  assign battChargeEn = ctrl_q.bcEn;                    // [RULE_14]
  assign irq          = |(status_q & mask_q);

  // Assertions
  sequence lowRun8(int i);
    lowSeen[i] [*8];
  endsequence

  // Last low sample of a run that reaches the single-pulse time
  sequence lastLow(int i);
    fst_q[i] == port_power_pkg::FLT_LOW1 && lowSeen[i]
      && run_q[i] + 1'b1 >= `PPS_CNT_W'(SINGLE_CYC);
  endsequence

  // A fresh low group while the double-pulse window is still open
  sequence lowInWindow(int i);
    fst_q[i] == port_power_pkg::FLT_GAP && lowSeen[i]
      && win_q[i] < `PPS_CNT_W'(DOUBLE_CYC);
  endsequence

  AST_DISABLED_DRIVES_LOW: assert property ( // [RULE_06]
    @(posedge clk) disable iff (!rst_n)
    !pinOn[0] |-> portPowerSensePinsOe[0] && !portPowerSensePinsOut[0]
      && !pullUpEn[0])
    else $error("disabled pin not driven low");
  AST_ENABLED_RELEASED: assert property ( // [RULE_07]
    @(posedge clk) disable iff (!rst_n)
    pinOn[1] |-> !portPowerSensePinsOe[1] && pullUpEn[1])
    else $error("enabled pin still driven");
  AST_GANG_ONE_PIN: assert property ( // [RULE_04]
    @(posedge clk) disable iff (!rst_n)
    ctrl_q.gang |-> pinOn[3:1] == 3'b000 && pinOn[0] == |portOn)
    else $error("ganged mode uses more than one pin");
  AST_COMBINED_PINS: assert property ( // [RULE_05]
    @(posedge clk) disable iff (!rst_n)
    !ctrl_q.gang |-> pinOn == portOn)
    else $error("combined pin mismatch");
  AST_PROC_SOURCE: assert property ( // [RULE_02]
    @(posedge clk) disable iff (!rst_n)
    ctrl_q.procSel && !ctrl_q.gang |-> portPowerSensePinsOe == ~ctrl_q.pwrEn)
    else $error("processor power enables not on pins");
  AST_HUB_SOURCE: assert property ( // [RULE_02]
    @(posedge clk) disable iff (!rst_n)
    !ctrl_q.procSel && !ctrl_q.gang |-> pullUpEn == hubPwrReq)
    else $error("hub power requests not on pins");
  AST_NO_SAMPLE_OFF: assert property ( // [RULE_11]
    @(posedge clk) disable iff (!rst_n)
    !pinOn[2] |=> fst_q[2] == port_power_pkg::FLT_IDLE)
    else $error("filter runs on disabled port");
  AST_SHORT_LOW_NO_EVENT: assert property ( // [RULE_10]
    @(posedge clk) disable iff (!rst_n)
    (fst_q[0] == port_power_pkg::FLT_IDLE && lowSeen[0]) ##0 lowRun8(0)
      |-> !event_s[0] || SINGLE_CYC <= 8)
    else $error("short low pulse tripped");
  AST_SINGLE_TRIPS: assert property ( // [RULE_12]
    @(posedge clk) disable iff (!rst_n)
    lastLow(0) |-> event_s[0])
    else $error("full single low pulse not tripped");
  AST_DOUBLE_TRIPS: assert property ( // [RULE_13]
    @(posedge clk) disable iff (!rst_n)
    lowInWindow(1) |-> event_s[1])
    else $error("second low group in window not tripped");
  AST_EVENT_LATCHES: assert property ( // [RULE_17]
    @(posedge clk) disable iff (!rst_n)
    event_s[1] |=> overCurrent[1])
    else $error("event not latched");
  AST_STATUS_HOLDS: assert property ( // [RULE_17]
    @(posedge clk) disable iff (!rst_n)
    overCurrent[0] && !wrHit |=> overCurrent[0])
    else $error("status dropped without clear");
  AST_STATUS_CLEARS: assert property ( // [RULE_17]
    @(posedge clk) disable iff (!rst_n)
    wrHit && avsAddress == `PPS_ADDR_STATUS && avsByteenable[0]
      && avsWritedata[0] && !event_s[0] |=> !overCurrent[0])
    else $error("status not cleared by a written one");
  AST_SINGLE_COUNT: assert property ( // [RULE_15]
    @(posedge clk) disable iff (!rst_n)
    event_s[0] && fst_q[0] == port_power_pkg::FLT_LOW1
      |-> run_q[0] + 1'b1 >= `PPS_CNT_W'(SINGLE_CYC))
    else $error("single trip before full time");
  AST_DOUBLE_WINDOW: assert property ( // [RULE_16]
    @(posedge clk) disable iff (!rst_n)
    event_s[1] && fst_q[1] == port_power_pkg::FLT_GAP
      |-> win_q[1] < `PPS_CNT_W'(DOUBLE_CYC))
    else $error("double trip outside window");
  AST_TRIP_REARMS: assert property ( // [RULE_10]
    @(posedge clk) disable iff (!rst_n)
    fst_q[0] == port_power_pkg::FLT_TRIP && !lowSeen[0]
      |=> fst_q[0] == port_power_pkg::FLT_IDLE)
    else $error("filter not re-armed after trip");
  AST_BC_OUT: assert property ( // [RULE_14]
    @(posedge clk) disable iff (!rst_n)
    wrHit && avsAddress == `PPS_ADDR_CTRL && avsByteenable[1]
      |=> battChargeEn == $past(avsWritedata[11:8]))
    else $error("charging flags not updated");

endmodule

// ---- test/power_switch_model.sv ----
// External power switches on the four power/sense lines.
// Assumes drive enable means the hub pulls the line low.
`timescale 1ns/1ns
module power_switch_model (
  input  wire logic       clk,
  input  wire logic [3:0] pinOut,
  input  wire logic [3:0] pinOe,
  input  wire logic [3:0] pullUpEn,
  input  wire logic [3:0] fault,
  output logic      [3:0] pinIn
);
  logic [3:0] floatQ = 4'h0;
  // An undriven, unpulled line wanders, so no level can be trusted
  always @(posedge clk) floatQ <= ~floatQ;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (fault[i]) pinIn[i] = 1'b0;
      else pinIn[i] = pullUpEn[i] ? 1'b1 : floatQ[i];
    end
  end
endmodule

// ---- test/port_power_sense_ctl_bench.sv ----
// Bench for the port power block: register tasks and pin stimulus.
// Assumes the switch model closes the loop on the sense lines.
`timescale 1ns/1ns
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %h got %h", n, e, g); errCount++; end end
module port_power_sense_ctl_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avsAddress = 4'h0;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic [3:0]  hubPwrReq = 4'h0;
  logic [3:0]  fault = 4'h0;
  logic [3:0]  pinIn, pinOut, pinOe, pullUpEn, overCurrent, battChargeEn;
  logic        irq;
  logic [31:0] rd;
  int          errCount = 0;
  int          numChecks = 0;
  // Short counts keep the run brief; expectations use these values
  localparam int SC = 20;
  localparam int DC = 80;

  initial forever #4 clk = ~clk;

  port_power_sense_ctl #(.SINGLE_CYC(SC), .DOUBLE_CYC(DC)) dut (
    .clk(clk), .rst_n(rst_n), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(4'hF),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .hubPwrReq(hubPwrReq), .portPowerSensePinsIn(pinIn),
    .portPowerSensePinsOut(pinOut), .portPowerSensePinsOe(pinOe),
    .pullUpEn(pullUpEn), .overCurrent(overCurrent),
    .battChargeEn(battChargeEn), .irq(irq));

  power_switch_model partner (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
    .pullUpEn(pullUpEn), .fault(fault), .pinIn(pinIn));

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int waits;
    waits = 0;
    @(posedge clk);
    avsRead <= ~w;
    avsWrite <= w;
    avsAddress <= a;
    avsWritedata <= d;
    // Only the watchdog ends a wait that never comes
    do begin
      @(posedge clk);
      waits++;
    end while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    `CHK("wait", 2, waits)
  endtask

  // Raise one port's fault, pulling its line low, for a number of cycles
  task automatic pulse(input int p, input int len);
    @(posedge clk);
    fault[p] <= 1'b1;
    repeat (len) @(posedge clk);
    fault[p] <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    print_verdict;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 4'h0, 0);
    `CHK("ctrl", 32'h0, rd)
    bus(0, 4'h2, 0);
    `CHK("mask", 32'h0, rd)
    bus(0, 4'h7, 0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("irq", 1'b0, irq)
    $display("done reset");

    hubPwrReq <= 4'h5;
    settle(2);
    `CHK("oe", 4'hA, pinOe)
    `CHK("pullup", 4'h5, pullUpEn)
    `CHK("out", 4'h0, pinOut & pinOe)
    $display("done hub");

    bus(1, 4'h0, 32'h0000_0A23);
    settle(2);
    `CHK("bc", 4'hA, battChargeEn)
    `CHK("oe", 4'hC, pinOe)
    bus(0, 4'h0, 0);
    `CHK("ctrl", 32'h0000_0A23, rd)
    // Pins word: enabled pins, pin levels, requested ports
    bus(0, 4'h3, 0);
    `CHK("pins", 32'h0000_0333, rd)
    $display("done proc");

    // One sample short of the single-pulse time must not trip
    pulse(0, SC - 1);
    settle(DC + 10);
    `CHK("oc", 4'h0, overCurrent)
    pulse(0, SC + 2);
    settle(2);
    `CHK("oc", 4'h1, overCurrent)
    `CHK("irq", 1'b0, irq)
    bus(0, 4'h1, 0);
    `CHK("status", 32'h1, rd)
    bus(1, 4'h2, 32'h1);
    settle(1);
    `CHK("irq", 1'b1, irq)
    bus(1, 4'h1, 32'h1);
    settle(1);
    `CHK("oc", 4'h0, overCurrent)
    `CHK("irq", 1'b0, irq)
    $display("done single");

    pulse(1, 3);
    repeat (3) @(posedge clk);
    pulse(1, 3);
    settle(3);
    `CHK("oc", 4'h2, overCurrent)
    pulse(2, 2 * SC);
    settle(3);
    `CHK("oc", 4'h2, overCurrent)
    bus(1, 4'h1, 32'hF);
    // Second group after the window has closed must not trip
    pulse(1, 3);
    settle(DC + 10);
    pulse(1, 3);
    settle(3);
    `CHK("oc", 4'h0, overCurrent)
    $display("done double");

    bus(1, 4'h0, 32'h0000_0034);
    settle(2);
    `CHK("oe", 4'hE, pinOe)
    `CHK("pullup", 4'h1, pullUpEn)
    pulse(0, SC + 2);
    settle(2);
    `CHK("oc", 4'h1, overCurrent)
    $display("done gang");
    print_verdict;
  end
endmodule
